// ---- core/pmt_timer.sv ----
// Prescaled 16-bit match/capture timer with AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps

module pmt_timer
  import pmt_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [pmt_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [pmt_pkg::DW-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [pmt_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [pmt_pkg::DW-1:0]      s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [pmt_pkg::NCAP-1:0] capture_inputs_a,
  output logic [pmt_pkg::NPIN-1:0]    match_outputs_a,
  output logic                        irq
);
  import pmt_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] dat,
                                          input logic [3:0] strb);
    logic [DW-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    logic hit;
    hit = (a[1:0] == 2'h0) && ((a <= OFS_CAP1) || (a == OFS_EXT_MATCH) || (a == OFS_CNT_CTL)
          || (a == OFS_PWM_EN) || (a == OFS_IRQ_MASK));
    return hit;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [1:0]                  ctrl_r, ctrl_nxt;
  logic [CW-1:0]               count_r, count_nxt;
  logic [CW-1:0]               plim_r, plim_nxt;
  logic [CW-1:0]               pcnt_r, pcnt_nxt;
  logic [3*NMATCH-1:0]         mctl_r, mctl_nxt;
  logic [NMATCH-1:0][CW-1:0]   mval_r, mval_nxt;
  logic [3*NCAP-1:0]           cctl_r, cctl_nxt;
  logic [NCAP-1:0][CW-1:0]     capv_r, capv_nxt;
  logic [EMR_ACT_BASE+2*NMATCH-1:0] emr_r, emr_nxt;
  logic [CNT_CLR_CAP:0]        cntc_r, cntc_nxt;
  logic [NMATCH-1:0]           pwmc_r, pwmc_nxt;
  logic [NIRQ-1:0]             flag_r, flag_nxt;
  logic [NIRQ-1:0]             mask_r, mask_nxt;
  logic [NMATCH-1:0]           mevt_r, mevt_nxt;
  logic                        zevt_r, zevt_nxt;
  logic [NPIN-1:0]             pwm_r, pwm_nxt;
  logic [NPIN-1:0]             pin_r, pin_nxt;
  logic                        irq_r, irq_nxt;
  logic [AW-1:0]               awa_r, awa_nxt;
  logic                        awh_r, awh_nxt;
  logic [DW-1:0]               wd_r, wd_nxt;
  logic [3:0]                  ws_r, ws_nxt;
  logic                        wh_r, wh_nxt;
  logic                        bv_r, bv_nxt;
  logic [1:0]                  br_r, br_nxt;
  logic                        rv_r, rv_nxt;
  logic [DW-1:0]               rd_r, rd_nxt;
  logic [1:0]                  rr_r, rr_nxt;
  pmt_edge_t [NCAP-1:0]        cap_edge;
  logic                        do_wr;

  pmt_cap_sync u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (capture_inputs_a),
    .edge_o   (cap_edge)
  );

  // ----------------------------------------
  // Bus channels
  // ----------------------------------------
  assign s_axi_awready = ~awh_r;
  assign s_axi_wready  = ~wh_r;
  assign s_axi_arready = ~rv_r;
  assign do_wr         = awh_r & wh_r & ~bv_r;

  always_comb begin
    awa_nxt = awa_r;
    awh_nxt = awh_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    wh_nxt  = wh_r;
    bv_nxt  = bv_r;
    br_nxt  = br_r;
    rv_nxt  = rv_r;
    rd_nxt  = rd_r;
    rr_nxt  = rr_r;
    if (s_axi_awvalid && !awh_r) begin
      awa_nxt = s_axi_awaddr;
      awh_nxt = 1'b1;
    end
    if (s_axi_wvalid && !wh_r) begin
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
      wh_nxt = 1'b1;
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    if (do_wr) begin
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = mapped(awa_r) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rv_r) begin
      rv_nxt = 1'b1;
      rr_nxt = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rd_nxt = '0;
      case (s_axi_araddr)
        OFS_IRQ_FLAGS: rd_nxt[NIRQ-1:0] = flag_r;
        OFS_CTRL:      rd_nxt[1:0]      = ctrl_r;
        OFS_COUNT:     rd_nxt[CW-1:0]   = count_r;
        OFS_PRE_LIM:   rd_nxt[CW-1:0]   = plim_r;
        OFS_PRE_CNT:   rd_nxt[CW-1:0]   = pcnt_r;
        OFS_MATCH_CTL: rd_nxt[3*NMATCH-1:0] = mctl_r;
        OFS_CAP_CTL:   rd_nxt[3*NCAP-1:0]   = cctl_r;
        OFS_CAP0:      rd_nxt[CW-1:0]   = capv_r[0];
        OFS_CAP1:      rd_nxt[CW-1:0]   = capv_r[1];
        OFS_EXT_MATCH: rd_nxt[EMR_ACT_BASE+2*NMATCH-1:0] = emr_r;
        OFS_CNT_CTL:   rd_nxt[CNT_CLR_CAP:0] = cntc_r;
        OFS_PWM_EN:    rd_nxt[NMATCH-1:0] = pwmc_r;
        OFS_IRQ_MASK:  rd_nxt[NIRQ-1:0] = mask_r;
        default: begin
          if (s_axi_araddr >= OFS_MATCH0 && s_axi_araddr <= OFS_MATCH3 && s_axi_araddr[1:0] == 2'h0) begin
            rd_nxt[CW-1:0] = mval_r[s_axi_araddr[3:2] - 2'h2];
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Timer core and registers
  // ----------------------------------------
  always_comb begin
    logic [DW-1:0]     wv;
    pmt_mode_t         mode;
    pmt_edge_t         src;
    pmt_edge_t         clr_src;
    logic              run, tick, step, rst_hit, stop_hit, clr_evt, cap_hit;
    logic [CW-1:0]     stepv;
    logic [NIRQ-1:0]   fset, fclr;
    pmt_act_t          act;
    run      = 1'b0;
    tick     = 1'b0;
    step     = 1'b0;
    stop_hit = 1'b0;
    rst_hit  = 1'b0;
    clr_evt  = 1'b0;
    cap_hit  = 1'b0;
    stepv    = '0;
    act      = ACT_NONE;
    wv       = merge('0, wd_r, ws_r);
    mode     = pmt_mode_t'(cntc_r[CNT_SEL_LSB-1:CNT_MODE_LSB]);
    src      = (cntc_r[CNT_SEL_LSB +: 2] == 2'h1) ? cap_edge[1] : cap_edge[0];
    clr_src  = cap_edge[cntc_r[CNT_CLR_CAP]];
    fset     = '0;
    fclr     = '0;
    ctrl_nxt = ctrl_r;
    count_nxt = count_r;
    plim_nxt = plim_r;
    pcnt_nxt = pcnt_r;
    mctl_nxt = mctl_r;
    mval_nxt = mval_r;
    cctl_nxt = cctl_r;
    capv_nxt = capv_r;
    emr_nxt  = emr_r;
    cntc_nxt = cntc_r;
    pwmc_nxt = pwmc_r;
    mask_nxt = mask_r;
    pwm_nxt  = pwm_r;
    // Software writes first; hardware updates below take precedence
    if (do_wr) begin
      case (awa_r)
        OFS_IRQ_FLAGS: fclr     = wv[NIRQ-1:0];
        OFS_CTRL:      ctrl_nxt = wv[1:0];
        OFS_COUNT:     count_nxt = wv[CW-1:0];
        OFS_PRE_LIM:   plim_nxt = wv[CW-1:0];
        OFS_PRE_CNT:   pcnt_nxt = wv[CW-1:0];
        OFS_MATCH_CTL: mctl_nxt = wv[3*NMATCH-1:0];
        OFS_CAP_CTL:   cctl_nxt = wv[3*NCAP-1:0];
        OFS_EXT_MATCH: emr_nxt  = wv[EMR_ACT_BASE+2*NMATCH-1:0];
        OFS_CNT_CTL:   cntc_nxt = wv[CNT_CLR_CAP:0];
        OFS_PWM_EN:    pwmc_nxt = wv[NMATCH-1:0];
        OFS_IRQ_MASK:  mask_nxt = wv[NIRQ-1:0];
        default: begin
          if (awa_r >= OFS_MATCH0 && awa_r <= OFS_MATCH3 && awa_r[1:0] == 2'h0) begin
            mval_nxt[awa_r[3:2] - 2'h2] = wv[CW-1:0];
          end
        end
      endcase
    end
    // Stop must freeze the count in the very cycle the enable clears
    for (int i = 0; i < NMATCH; i++) begin
      stop_hit = stop_hit | (mevt_r[i] & mctl_r[MCTL_STRIDE*i + MCTL_STOP]);
      rst_hit  = rst_hit | ((count_r == mval_r[i]) & mctl_r[MCTL_STRIDE*i + MCTL_RST]);
    end
    run  = ctrl_r[CTRL_EN] & ~ctrl_r[CTRL_RST] & ~stop_hit;
    tick = run & ((mode == MODE_TIMER)
                  | (src.rise & mode[0]) | (src.fall & mode[1]));
    step  = tick & (pcnt_r == plim_r);
    stepv = rst_hit ? '0 : count_r + 16'h0001;
    if (tick) begin
      pcnt_nxt = step ? '0 : pcnt_r + 16'h0001;
    end
    if (step) begin
      count_nxt = stepv;
    end
    for (int i = 0; i < NMATCH; i++) begin
      mevt_nxt[i] = step & (stepv == mval_r[i]);
    end
    zevt_nxt = step & (stepv == '0);
    clr_evt  = cntc_r[CNT_CLR_EN] & (cntc_r[CNT_CLR_EDGE] ? clr_src.fall : clr_src.rise);
    if (clr_evt || ctrl_r[CTRL_RST]) begin
      count_nxt = '0;
      pcnt_nxt  = '0;
    end
    for (int c = 0; c < NCAP; c++) begin
      cap_hit = (cap_edge[c].rise & cctl_r[CCTL_STRIDE*c + CCTL_RISE])
              | (cap_edge[c].fall & cctl_r[CCTL_STRIDE*c + CCTL_FALL]);
      if (cap_hit) begin
        capv_nxt[c] = count_r;
      end
      fset[IRQ_CAP_BASE + c] = cap_hit & cctl_r[CCTL_STRIDE*c + CCTL_INT];
    end
    // Match consequences land one clock after the count shows the value
    for (int i = 0; i < NMATCH; i++) begin
      fset[i] = mevt_r[i] & mctl_r[MCTL_STRIDE*i + MCTL_INT];
      act = pmt_act_t'(emr_r[EMR_ACT_BASE + 2*i +: 2]);
      if (mevt_r[i] && !pwmc_r[i]) begin
        case (act)
          ACT_LOW:    emr_nxt[i] = 1'b0;
          ACT_HIGH:   emr_nxt[i] = 1'b1;
          ACT_TOGGLE: emr_nxt[i] = ~emr_r[i];
          default:    emr_nxt[i] = emr_r[i];
        endcase
      end
    end
    if (stop_hit) begin
      ctrl_nxt[CTRL_EN] = 1'b0;
    end
    for (int j = 0; j < NPIN; j++) begin
      // Zero match fires together with the period start, so high wins
      if (mevt_r[j]) begin
        pwm_nxt[j] = 1'b1;
      end else if (zevt_r) begin
        pwm_nxt[j] = 1'b0;
      end
      pin_nxt[j] = pwmc_nxt[j] ? pwm_nxt[j] : emr_nxt[j];
    end
    flag_nxt = (flag_r & ~fclr) | fset;
    irq_nxt  = |(flag_nxt & mask_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r  <= '0;
      count_r <= '0;
      plim_r  <= '0;
      pcnt_r  <= '0;
      mctl_r  <= '0;
      mval_r  <= '0;
      cctl_r  <= '0;
      capv_r  <= '0;
      emr_r   <= '0;
      cntc_r  <= '0;
      pwmc_r  <= '0;
      flag_r  <= '0;
      mask_r  <= IRQ_MASK_RST;
      mevt_r  <= '0;
      zevt_r  <= 1'b0;
      pwm_r   <= '0;
      pin_r   <= '0;
      irq_r   <= 1'b0;
      awa_r   <= '0;
      awh_r   <= 1'b0;
      wd_r    <= '0;
      ws_r    <= '0;
      wh_r    <= 1'b0;
      bv_r    <= 1'b0;
      br_r    <= RESP_OKAY;
      rv_r    <= 1'b0;
      rd_r    <= '0;
      rr_r    <= RESP_OKAY;
    end else begin
      ctrl_r  <= ctrl_nxt;
      count_r <= count_nxt;
      plim_r  <= plim_nxt;
      pcnt_r  <= pcnt_nxt;
      mctl_r  <= mctl_nxt;
      mval_r  <= mval_nxt;
      cctl_r  <= cctl_nxt;
      capv_r  <= capv_nxt;
      emr_r   <= emr_nxt;
      cntc_r  <= cntc_nxt;
      pwmc_r  <= pwmc_nxt;
      flag_r  <= flag_nxt;
      mask_r  <= mask_nxt;
      mevt_r  <= mevt_nxt;
      zevt_r  <= zevt_nxt;
      pwm_r   <= pwm_nxt;
      pin_r   <= pin_nxt;
      irq_r   <= irq_nxt;
      awa_r   <= awa_nxt;
      awh_r   <= awh_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      wh_r    <= wh_nxt;
      bv_r    <= bv_nxt;
      br_r    <= br_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      rr_r    <= rr_nxt;
    end
  end

  assign s_axi_bvalid    = bv_r;
  assign s_axi_bresp     = br_r;
  assign s_axi_rvalid    = rv_r;
  assign s_axi_rdata     = rd_r;
  assign s_axi_rresp     = rr_r;
  assign match_outputs_a = pin_r;
  assign irq             = irq_r;

endmodule

// ---- core/pmt_pkg.sv ----
// Constants, field layout and types shared by the prescaled match/capture timer
package pmt_pkg;

  // ----------------------------------------
  // Widths and counts
  // ----------------------------------------
  localparam int unsigned AW      = 8;
  localparam int unsigned DW      = 32;
  localparam int unsigned CW      = 16;
  localparam int unsigned NMATCH  = 4;
  localparam int unsigned NPIN    = 3;
  localparam int unsigned NCAP    = 2;
  localparam int unsigned NIRQ    = NMATCH + NCAP;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [AW-1:0] OFS_IRQ_FLAGS = 8'h00;
  localparam logic [AW-1:0] OFS_CTRL      = 8'h04;
  localparam logic [AW-1:0] OFS_COUNT     = 8'h08;
  localparam logic [AW-1:0] OFS_PRE_LIM   = 8'h0C;
  localparam logic [AW-1:0] OFS_PRE_CNT   = 8'h10;
  localparam logic [AW-1:0] OFS_MATCH_CTL = 8'h14;
  localparam logic [AW-1:0] OFS_MATCH0    = 8'h18;
  localparam logic [AW-1:0] OFS_MATCH2    = 8'h20;
  localparam logic [AW-1:0] OFS_MATCH3    = 8'h24;
  localparam logic [AW-1:0] OFS_CAP_CTL   = 8'h28;
  localparam logic [AW-1:0] OFS_CAP0      = 8'h2C;
  localparam logic [AW-1:0] OFS_CAP1      = 8'h30;
  localparam logic [AW-1:0] OFS_EXT_MATCH = 8'h3C;
  localparam logic [AW-1:0] OFS_CNT_CTL   = 8'h70;
  localparam logic [AW-1:0] OFS_PWM_EN    = 8'h74;
  localparam logic [AW-1:0] OFS_IRQ_MASK  = 8'h78;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned CTRL_EN       = 0;
  localparam int unsigned CTRL_RST      = 1;
  localparam int unsigned MCTL_STRIDE   = 3;
  localparam int unsigned MCTL_INT      = 0;
  localparam int unsigned MCTL_RST      = 1;
  localparam int unsigned MCTL_STOP     = 2;
  localparam int unsigned CCTL_STRIDE   = 3;
  localparam int unsigned CCTL_RISE     = 0;
  localparam int unsigned CCTL_FALL     = 1;
  localparam int unsigned CCTL_INT      = 2;
  localparam int unsigned EMR_ACT_BASE  = 4;
  localparam int unsigned CNT_MODE_LSB  = 0;
  localparam int unsigned CNT_SEL_LSB   = 2;
  localparam int unsigned CNT_CLR_EN    = 4;
  localparam int unsigned CNT_CLR_EDGE  = 5;
  localparam int unsigned CNT_CLR_CAP   = 6;
  localparam int unsigned IRQ_CAP_BASE  = NMATCH;

  // ----------------------------------------
  // Reset values and bus responses
  // ----------------------------------------
  localparam logic [NIRQ-1:0] IRQ_MASK_RST = 6'h3F;
  localparam logic [1:0]      RESP_OKAY    = 2'h0;
  localparam logic [1:0]      RESP_SLVERR  = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_RISE  = 2'h1,
    MODE_FALL  = 2'h2,
    MODE_BOTH  = 2'h3
  } pmt_mode_t;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_LOW    = 2'h1,
    ACT_HIGH   = 2'h2,
    ACT_TOGGLE = 2'h3
  } pmt_act_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } pmt_edge_t;

endpackage

// ---- core/pmt_cap_sync.sv ----
// Capture input synchroniser with debounced edge detection
`timescale 1ns/100ps
module pmt_cap_sync
  import pmt_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [pmt_pkg::NCAP-1:0] async_in,
  output pmt_pkg::pmt_edge_t [pmt_pkg::NCAP-1:0] edge_o
);
  import pmt_pkg::*;

  logic      [NCAP-1:0] s1_r;
  logic      [NCAP-1:0] s2_r;
  logic      [NCAP-1:0] s3_r;
  logic      [NCAP-1:0] lvl_r;
  logic      [NCAP-1:0] lvl_nxt;
  pmt_edge_t [NCAP-1:0] edge_r;
  pmt_edge_t [NCAP-1:0] edge_nxt;

  // ----------------------------------------
  // Edge qualification
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCAP; g++) begin : g_cap
      always_comb begin
        lvl_nxt[g]       = lvl_r[g];
        edge_nxt[g].rise = 1'b0;
        edge_nxt[g].fall = 1'b0;
        // Change accepted only once stages two and three agree
        if ((s2_r[g] == s3_r[g]) && (s3_r[g] != lvl_r[g])) begin
          lvl_nxt[g]       = s3_r[g];
          edge_nxt[g].rise = s3_r[g];
          edge_nxt[g].fall = ~s3_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      lvl_r  <= '0;
      edge_r <= '0;
    end else begin
      s1_r   <= async_in;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      lvl_r  <= lvl_nxt;
      edge_r <= edge_nxt;
    end
  end

  assign edge_o = edge_r;

endmodule

// ---- dv/pmt_pin_model.sv ----
// Capture pin source standing in for the external signal driver
`timescale 1ns/100ps
module pmt_pin_model (
  input  wire logic       aclk,
  input  wire logic [1:0] req,
  input  wire logic       slow,
  output logic [1:0]      cap
);
  logic [1:0] dly_r;
  // Slow mode delays the pin a clock, still holding each level long enough to sync
  always @(posedge aclk) begin
    dly_r <= req;
    cap   <= slow ? dly_r : req;
  end
endmodule

// ---- dv/pmt_timer_chk.sv ----
// Register bus checker for the prescaled match/capture timer
`timescale 1ns/100ps
module pmt_timer_chk
  import pmt_pkg::*;
(
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic [pmt_pkg::AW-1:0] s_axi_araddr,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [pmt_pkg::DW-1:0] s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  a_cnt_width: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_COUNT |=> s_axi_rdata[31:16] == 16'h0)
    else $error("count wider than 16 bits");
  a_cap_width: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_CAP0 |=> s_axi_rdata[31:16] == 16'h0)
    else $error("capture wider than 16 bits");
  a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h40
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

// ---- dv/pmt_timer_tb.sv ----
// Self-checking bench for the prescaled match/capture timer
`timescale 1ns/100ps
module pmt_timer_tb;
  import pmt_pkg::*;
  logic            aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready, irq, slow;
  logic [AW-1:0]   awaddr, araddr;
  logic [DW-1:0]   wdata, rdata, d;
  logic [1:0]      bresp, rresp, resp, req, cap;
  logic [3:0]      wstrb;
  logic [NPIN-1:0] mo;
  logic [7:0]      offs [15] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24,
                                 8'h28, 8'h2C, 8'h30, 8'h3C, 8'h70, 8'h74, 8'h78};
  int              bad_count, check_count, cyc, n, k, pr, mv;
  int              seed = 32'h63b50a57;

  pmt_timer i_pmt_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .capture_inputs_a(cap),
    .match_outputs_a(mo), .irq(irq));
  pmt_pin_model i_pmt_pin_model (.aclk(aclk), .req(req), .slow(slow), .cap(cap));

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ready is raised one edge late so the slave must hold its answer
  task automatic wr(input logic [AW-1:0] a, input int v);
    logic aw_ok, w_ok, b_ok, bv_seen;
    b_ok    = 1'b0;
    awaddr  <= a;
    wdata   <= DW'(v);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!b_ok) begin
      // Handshakes judged on settled values, acted on at the next edge
      @(negedge aclk);
      aw_ok   = awvalid & awready;
      w_ok    = wvalid & wready;
      bv_seen = bvalid;
      b_ok    = bvalid & bready;
      if (b_ok) resp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (bv_seen && !b_ok) bready <= 1'b1;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    logic ar_ok, r_ok, rv_seen;
    r_ok    = 1'b0;
    v       = '0;
    araddr  <= a;
    arvalid <= 1'b1;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok   = arvalid & arready;
      rv_seen = rvalid;
      r_ok    = rvalid & rready;
      if (r_ok) begin
        v    = rdata;
        resp = rresp;
      end
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
      if (rv_seen && !r_ok) rready <= 1'b1;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic pulse(input int c);
    slow <= 1'($random(seed));
    req[c] <= 1'b1;
    repeat (4) @(posedge aclk);
    req[c] <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
  task automatic ones(output int c);
    c = 0;
    repeat (20) @(posedge aclk);
    repeat (40) @(negedge aclk) if (mo[0] === 1'b1) c++;
    @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {awaddr, araddr, wdata, req} = '0;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (offs[j]) begin
      rd(offs[j], d);
      chk(d, offs[j] == OFS_IRQ_MASK ? 32'h3F : 32'h0);
    end
    chk(32'(mo), 32'h0);
    rd(8'h40, d);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(8'h44, 1);
    chk(32'(resp), 32'(RESP_SLVERR));
    // ----------------------------------------
    // Reset on match, random prescale and match
    // ----------------------------------------
    for (k = 0; k < 3; k++) begin
      pr = $random(seed) & 3;
      mv = 1 + ($random(seed) & 7);
      wr(OFS_CTRL, 2);
      wr(OFS_PRE_LIM, pr);
      wr(OFS_MATCH0, mv);
      wr(OFS_MATCH_CTL, 3);
      wr(OFS_EXT_MATCH, 32'h30);
      wr(OFS_CTRL, 1);
      @(mo[0]);
      n = cyc;
      @(mo[0]);
      chk(cyc - n, (mv + 1) * (pr + 1));
      wr(OFS_CTRL, 0);
      rd(OFS_IRQ_FLAGS, d);
      chk(d, 1);
      chk(32'(irq), 1);
      wr(OFS_IRQ_MASK, 0);
      @(posedge aclk);
      chk(32'(irq), 0);
      wr(OFS_IRQ_MASK, 32'h3F);
      wr(OFS_IRQ_FLAGS, 1);
      rd(OFS_IRQ_FLAGS, d);
      chk(d, 0);
    end
    // Stop on match freezes at the match value
    wr(OFS_CTRL, 2);
    wr(OFS_MATCH_CTL, 5);
    wr(OFS_PRE_LIM, 2);
    wr(OFS_MATCH0, 6);
    wr(OFS_CTRL, 1);
    repeat (40) @(posedge aclk);
    rd(OFS_CTRL, d);
    chk(d, 0);
    rd(OFS_COUNT, d);
    chk(d, 6);
    wr(OFS_IRQ_FLAGS, 32'h3F);
    // Wrap with no resetting match
    wr(OFS_MATCH_CTL, 0);
    wr(OFS_PRE_LIM, 0);
    wr(OFS_COUNT, 32'hFFFE);
    wr(OFS_CTRL, 1);
    repeat (4) @(posedge aclk);
    rd(OFS_COUNT, d);
    chk(32'(d < 32'h100), 1);
    // ----------------------------------------
    // Capture, capture clear, counter mode
    // ----------------------------------------
    wr(OFS_CTRL, 0);
    wr(OFS_PRE_LIM, 32'hFFFF);
    wr(OFS_COUNT, 32'h1234);
    wr(OFS_CAP_CTL, 5);
    wr(OFS_CTRL, 1);
    pulse(0);
    rd(OFS_CAP0, d);
    chk(d, 32'h1234);
    rd(OFS_IRQ_FLAGS, d);
    chk(d, 32'h10);
    wr(OFS_CNT_CTL, 32'h10);
    wr(OFS_COUNT, 32'h55);
    pulse(0);
    rd(OFS_COUNT, d);
    chk(d, 0);
    wr(OFS_CNT_CTL, 5);
    wr(OFS_PRE_LIM, 0);
    wr(OFS_CTRL, 2);
    wr(OFS_CTRL, 1);
    n = 1 + ($random(seed) & 3);
    repeat (n) pulse(1);
    rd(OFS_COUNT, d);
    chk(d, n);
    wr(OFS_CNT_CTL, 0);
    // Pin actions: none, low, high on match 2
    wr(OFS_MATCH2 - 8'h0, 3);
    for (k = 0; k < 3; k++) begin
      wr(OFS_CTRL, 2);
      wr(OFS_EXT_MATCH, (k << 8) | (k != 2 ? 4 : 0));
      wr(OFS_CTRL, 1);
      repeat (8) @(posedge aclk);
      chk(32'(mo[2]), 32'(k != 1));
    end
    // ----------------------------------------
    // PWM on pin 0, period set by match 3
    // ----------------------------------------
    wr(OFS_CTRL, 2);
    wr(OFS_MATCH3, 9);
    wr(OFS_MATCH_CTL, 32'h400);
    wr(OFS_MATCH0, 4);
    wr(OFS_EXT_MATCH, 0);
    wr(OFS_PWM_EN, 1);
    wr(OFS_CTRL, 1);
    ones(n);
    chk(n, 24);
    wr(OFS_MATCH0, 12);
    ones(n);
    chk(n, 0);
    wr(OFS_MATCH0, 0);
    ones(n);
    chk(n, 40);
    end_of_test();
  end
endmodule

bind pmt_timer pmt_timer_chk i_pmt_timer_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
